//--- pdc_pkg.sv
// pdc_pkg: register map, field positions and reset values of the divider path block
package pdc_pkg;
    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [4:0] IDX_REF_RATIO = 5'h02;
    localparam logic [4:0] IDX_N_INT = 5'h03;
    localparam logic [4:0] IDX_N_FRAC = 5'h04;
    localparam logic [4:0] IDX_MOD_CFG = 5'h06;
    localparam logic [4:0] IDX_ANA_EN = 5'h08;
    localparam logic [4:0] IDX_CP_CTL = 5'h09;
    localparam logic [4:0] IDX_PIN_CFG = 5'h0f;
    localparam logic [4:0] IDX_STATUS = 5'h10;
    // ------------------------------------------------------------
    // widths and field positions
    // ------------------------------------------------------------
    localparam int REG_W = 24;
    localparam int REF_W = 14;
    localparam int N_W = 19;
    localparam int FRAC_W = 24;
    localparam int DSM_LSB = 2;
    localparam int DIV2_BIT = 19;
    localparam int HF_BIT = 21;
    localparam int CP_MAG_LSB = 14;
    localparam int CP_MAG_W = 7;
    localparam int CP_DIR_LSB = 21;
    localparam int PIN_SEL_W = 5;
    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [1:0] DSM_INTEGER = 2'h0;
    localparam logic [1:0] DSM_MODE_A = 2'h1;
    localparam logic [1:0] CP_DIR_UP = 2'h1;
    localparam logic [1:0] CP_DIR_DN = 2'h2;
    localparam logic [4:0] PIN_SEL_REF = 5'h09;
    localparam logic [4:0] PIN_SEL_N = 5'h0a;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [23:0] RST_REF_RATIO = 24'h000001;
    localparam logic [23:0] RST_N_INT = 24'h000010;
    localparam logic [23:0] RST_ZERO = 24'h000000;
endpackage : pdc_pkg

//--- pdc_top.sv
// pdc_top: reference and feedback dividers, modulator and their control registers
`timescale 1ns/1ps

module pdc_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // divider inputs from pins
    input wire logic ref_in_i,
    input wire logic vco_in_i,
    // analog controls
    output logic ref_buf_hf_mode_o,
    output logic [1:0] dsm_mode_o,
    output logic cp_offset_up_o,
    output logic cp_offset_dn_o,
    output logic [pdc_pkg::CP_MAG_W-1:0] cp_offset_mag_o,
    // divider outputs to phase detector
    output logic ref_div_tick_o,
    output logic n_div_tick_o,
    // test pin
    output logic lock_detect_serial_out_pin_o,
    output logic lock_detect_serial_out_pin_oe_o
);
    import pdc_pkg::*;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    logic [23:0] ref_ratio_reg, ref_ratio_next;
    logic [23:0] n_int_reg, n_int_next;
    logic [23:0] n_frac_reg, n_frac_next;
    logic [23:0] mod_cfg_reg, mod_cfg_next;
    logic [23:0] ana_en_reg, ana_en_next;
    logic [23:0] cp_ctl_reg, cp_ctl_next;
    logic [23:0] pin_cfg_reg, pin_cfg_next;
    logic [31:0] dat_reg, dat_next;
    logic ack_reg, ack_next;
    logic [23:0] status_w;
    logic req;
    logic [4:0] idx;

    // byte-lane merge, used for every writable register
    function automatic logic [23:0] lane_merge(input logic [23:0] old,
                                               input logic [31:0] dat,
                                               input logic [3:0] sel);
        logic [23:0] r;
        r = old;
        if (sel[0]) r[7:0] = dat[7:0];
        if (sel[1]) r[15:8] = dat[15:8];
        if (sel[2]) r[23:16] = dat[23:16];
        return r;
    endfunction : lane_merge

    assign req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign idx = wb_adr_i[6:2];

    // decode, write with byte lanes, capture read data; unmapped reads zero
    always_comb
    begin
        ref_ratio_next = ref_ratio_reg;
        n_int_next = n_int_reg;
        n_frac_next = n_frac_reg;
        mod_cfg_next = mod_cfg_reg;
        ana_en_next = ana_en_reg;
        cp_ctl_next = cp_ctl_reg;
        pin_cfg_next = pin_cfg_reg;
        dat_next = dat_reg;
        ack_next = req;
        if (req && wb_we_i && wb_adr_i[7] == 1'b0)
        begin
            case (idx)
                IDX_REF_RATIO: ref_ratio_next = lane_merge(ref_ratio_reg, wb_dat_i, wb_sel_i);
                IDX_N_INT: n_int_next = lane_merge(n_int_reg, wb_dat_i, wb_sel_i);
                IDX_N_FRAC: n_frac_next = lane_merge(n_frac_reg, wb_dat_i, wb_sel_i);
                IDX_MOD_CFG: mod_cfg_next = lane_merge(mod_cfg_reg, wb_dat_i, wb_sel_i);
                IDX_ANA_EN: ana_en_next = lane_merge(ana_en_reg, wb_dat_i, wb_sel_i);
                IDX_CP_CTL: cp_ctl_next = lane_merge(cp_ctl_reg, wb_dat_i, wb_sel_i);
                IDX_PIN_CFG: pin_cfg_next = lane_merge(pin_cfg_reg, wb_dat_i, wb_sel_i);
                default: ;
            endcase
        end
        if (req && !wb_we_i)
        begin
            dat_next = 32'h00000000;
            if (wb_adr_i[7] == 1'b0)
            begin
                case (idx)
                    IDX_REF_RATIO: dat_next[23:0] = ref_ratio_reg;
                    IDX_N_INT: dat_next[23:0] = n_int_reg;
                    IDX_N_FRAC: dat_next[23:0] = n_frac_reg;
                    IDX_MOD_CFG: dat_next[23:0] = mod_cfg_reg;
                    IDX_ANA_EN: dat_next[23:0] = ana_en_reg;
                    IDX_CP_CTL: dat_next[23:0] = cp_ctl_reg;
                    IDX_PIN_CFG: dat_next[23:0] = pin_cfg_reg;
                    IDX_STATUS: dat_next[23:0] = status_w;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ref_ratio_reg <= RST_REF_RATIO;
            n_int_reg <= RST_N_INT;
            n_frac_reg <= RST_ZERO;
            mod_cfg_reg <= RST_ZERO;
            ana_en_reg <= RST_ZERO;
            cp_ctl_reg <= RST_ZERO;
            pin_cfg_reg <= RST_ZERO;
            dat_reg <= 32'h00000000;
            ack_reg <= 1'b0;
        end
        else
        begin
            ref_ratio_reg <= ref_ratio_next;
            n_int_reg <= n_int_next;
            n_frac_reg <= n_frac_next;
            mod_cfg_reg <= mod_cfg_next;
            ana_en_reg <= ana_en_next;
            cp_ctl_reg <= cp_ctl_next;
            pin_cfg_reg <= pin_cfg_next;
            dat_reg <= dat_next;
            ack_reg <= ack_next;
        end
    end

    assign wb_dat_o = dat_reg;
    assign wb_ack_o = ack_reg;

    // ------------------------------------------------------------
    // pin synchronisers and edge detect
    // ------------------------------------------------------------
    // pins are sampled at clk, so inputs must stay well below half of clk
    logic [2:0] ref_sync_reg, vco_sync_reg;
    logic ref_edge, vco_edge;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ref_sync_reg <= 3'h0;
            vco_sync_reg <= 3'h0;
        end
        else
        begin
            ref_sync_reg <= {ref_sync_reg[1:0], ref_in_i};
            vco_sync_reg <= {vco_sync_reg[1:0], vco_in_i};
        end
    end

    assign ref_edge = ref_sync_reg[1] && !ref_sync_reg[2];
    assign vco_edge = vco_sync_reg[1] && !vco_sync_reg[2];

    // ------------------------------------------------------------
    // dividers and modulator
    // ------------------------------------------------------------
    logic [REF_W-1:0] ref_cnt_reg, ref_cnt_next, r_eff;
    logic ref_tick_reg, ref_tick_next, ref_tog_reg, ref_tog_next;
    logic pre_tog_reg, pre_tog_next, pre_edge, div2_en;
    logic [N_W-1:0] n_cnt_reg, n_cnt_next, n_cur_reg, n_cur_next;
    logic n_tick_reg, n_tick_next, n_tog_reg, n_tog_next;
    logic [FRAC_W-1:0] acc1_reg, acc1_next, acc2_reg, acc2_next;
    logic c2_prev_reg, c2_prev_next;
    logic [FRAC_W:0] sum1, sum2;
    logic [N_W+1:0] n_calc;
    logic [1:0] dsm;
    logic pin_reg, pin_next;
    logic [PIN_SEL_W-1:0] pin_sel;

    // ratio 0 is treated as 1 so the divider never stalls
    assign r_eff = (ref_ratio_reg[REF_W-1:0] == '0) ? 14'h0001 : ref_ratio_reg[REF_W-1:0];
    assign div2_en = ana_en_reg[DIV2_BIT];
    assign dsm = mod_cfg_reg[DSM_LSB+1:DSM_LSB];
    assign pin_sel = pin_cfg_reg[PIN_SEL_W-1:0];
    // with div2 on, only every second vco edge reaches the counter
    assign pre_edge = vco_edge && (!div2_en || pre_tog_reg);
    assign sum1 = {1'b0, acc1_reg} + {1'b0, n_frac_reg};
    assign sum2 = {1'b0, acc2_reg} + {1'b0, sum1[FRAC_W-1:0]};

    // next ratio: integer, first order (mode a) or two-stage noise shaping
    always_comb
    begin
        n_calc = {2'b00, n_int_reg[N_W-1:0]};
        if (dsm == DSM_MODE_A)
        begin
            n_calc = n_calc + {20'h00000, sum1[FRAC_W]};
        end
        else if (dsm != DSM_INTEGER)
        begin
            // second stage trades in-band noise for out-of-band
            n_calc = n_calc + {20'h00000, sum1[FRAC_W]} + {20'h00000, sum2[FRAC_W]}
                     - {20'h00000, c2_prev_reg};
        end
    end

    // counting, run on the synchronised edges
    always_comb
    begin
        ref_cnt_next = ref_cnt_reg;
        ref_tick_next = 1'b0;
        ref_tog_next = ref_tog_reg;
        pre_tog_next = pre_tog_reg;
        n_cnt_next = n_cnt_reg;
        n_cur_next = n_cur_reg;
        n_tick_next = 1'b0;
        n_tog_next = n_tog_reg;
        acc1_next = acc1_reg;
        acc2_next = acc2_reg;
        c2_prev_next = c2_prev_reg;
        if (ref_edge)
        begin
            if (ref_cnt_reg >= r_eff - 14'h0001)
            begin
                ref_cnt_next = '0;
                ref_tick_next = 1'b1;
                ref_tog_next = !ref_tog_reg;
            end
            else
            begin
                ref_cnt_next = ref_cnt_reg + 14'h0001;
            end
        end
        if (vco_edge)
        begin
            pre_tog_next = div2_en ? !pre_tog_reg : 1'b0;
        end
        if (pre_edge)
        begin
            if (n_cnt_reg >= n_cur_reg - 19'h00001)
            begin
                n_cnt_next = '0;
                n_tick_next = 1'b1;
                n_tog_next = !n_tog_reg;
                n_cur_next = n_calc[N_W-1:0];
                if (dsm != DSM_INTEGER)
                begin
                    acc1_next = sum1[FRAC_W-1:0];
                    acc2_next = sum2[FRAC_W-1:0];
                    c2_prev_next = sum2[FRAC_W];
                end
            end
            else
            begin
                n_cnt_next = n_cnt_reg + 19'h00001;
            end
        end
        // test pin view of either divider
        case (pin_sel)
            PIN_SEL_REF: pin_next = ref_tog_reg;
            PIN_SEL_N: pin_next = n_tog_reg;
            default: pin_next = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ref_cnt_reg <= '0;
            ref_tick_reg <= 1'b0;
            ref_tog_reg <= 1'b0;
            pre_tog_reg <= 1'b0;
            n_cnt_reg <= '0;
            n_cur_reg <= RST_N_INT[N_W-1:0];
            n_tick_reg <= 1'b0;
            n_tog_reg <= 1'b0;
            acc1_reg <= '0;
            acc2_reg <= '0;
            c2_prev_reg <= 1'b0;
            pin_reg <= 1'b0;
        end
        else
        begin
            ref_cnt_reg <= ref_cnt_next;
            ref_tick_reg <= ref_tick_next;
            ref_tog_reg <= ref_tog_next;
            pre_tog_reg <= pre_tog_next;
            n_cnt_reg <= n_cnt_next;
            n_cur_reg <= n_cur_next;
            n_tick_reg <= n_tick_next;
            n_tog_reg <= n_tog_next;
            acc1_reg <= acc1_next;
            acc2_reg <= acc2_next;
            c2_prev_reg <= c2_prev_next;
            pin_reg <= pin_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // comparison rate limits are software's job; nothing checks them here
    assign ref_div_tick_o = ref_tick_reg;
    assign n_div_tick_o = n_tick_reg;
    assign ref_buf_hf_mode_o = ana_en_reg[HF_BIT];
    assign dsm_mode_o = dsm;
    // both directions set at once means no offset at all
    assign cp_offset_up_o = (cp_ctl_reg[CP_DIR_LSB+1:CP_DIR_LSB] == CP_DIR_UP);
    assign cp_offset_dn_o = (cp_ctl_reg[CP_DIR_LSB+1:CP_DIR_LSB] == CP_DIR_DN);
    assign cp_offset_mag_o = cp_ctl_reg[CP_MAG_LSB+CP_MAG_W-1:CP_MAG_LSB];
    assign lock_detect_serial_out_pin_o = pin_reg;
    assign lock_detect_serial_out_pin_oe_o = 1'b1;
    assign status_w = {3'h0, ref_tog_reg, n_tog_reg, n_cur_reg};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_single_pulse_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse");
    ref_ratio_one_a: assert property ((ref_edge && r_eff == 14'h0001) |=> ref_div_tick_o)
        else $error("ratio one missed a tick");
    // a smaller ratio written mid-count is only pulled back in at the next edge
    ref_cnt_range_a: assert property (ref_edge |=>
        (ref_cnt_reg < r_eff || $changed(r_eff)))
        else $error("reference count out of range");
    pin_ref_view_a: assert property ((pin_sel == PIN_SEL_REF) [*2] |->
        lock_detect_serial_out_pin_o == $past(ref_tog_reg))
        else $error("pin does not show reference divider");
    div2_skip_a: assert property ((vco_edge && div2_en && !pre_tog_reg) |-> !pre_edge)
        else $error("divide-by-2 passed an odd edge");
    n_wrap_a: assert property (n_div_tick_o |-> n_cnt_reg == 19'h00000)
        else $error("feedback count not cleared on tick");
    int_mode_ratio_a: assert property ((pre_edge && dsm == DSM_INTEGER &&
        n_cnt_reg >= n_cur_reg - 19'h00001) |=> n_cur_reg == $past(n_int_reg[N_W-1:0]))
        else $error("integer mode ratio wrong");
    mode_a_carry_a: assert property ((n_tick_next && dsm == DSM_MODE_A && !sum1[FRAC_W])
        |=> n_cur_reg == $past(n_int_reg[N_W-1:0]))
        else $error("mode a added a carry that was not there");
    hf_write_a: assert property ((req && wb_we_i && idx == IDX_ANA_EN && !wb_adr_i[7] &&
        wb_sel_i[2]) |=> ref_buf_hf_mode_o == $past(wb_dat_i[HF_BIT]))
        else $error("high-frequency bit not updated");
    cp_dir_excl_a: assert property (!(cp_offset_up_o && cp_offset_dn_o))
        else $error("offset drawn both ways");
endmodule : pdc_top

//--- tb.sv
// tb: self-checking bench for the divider path block
`timescale 1ns/1ps
module tb;
    import pdc_pkg::*;
    // ------------------------------------------------------------
    // stimulus, observed ports and bookkeeping
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic ref_in_i = 1'b0;
    logic vco_in_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, hf, up, dn, rtick, ntick, pin, pin_oe;
    logic [1:0] dsm;
    logic [CP_MAG_W-1:0] mag;
    logic pin_d = 1'b0;
    logic [31:0] exp_q[$];
    int failures = 0;
    int total_checks = 0;
    int ref_cnt = 0;
    int n_cnt = 0;
    int pin_cnt = 0;

    // 25 MHz clock
    always #20 clk_i = ~clk_i;

    pdc_top uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ref_in_i(ref_in_i), .vco_in_i(vco_in_i),
        .ref_buf_hf_mode_o(hf), .dsm_mode_o(dsm), .cp_offset_up_o(up), .cp_offset_dn_o(dn),
        .cp_offset_mag_o(mag), .ref_div_tick_o(rtick), .n_div_tick_o(ntick),
        .lock_detect_serial_out_pin_o(pin), .lock_detect_serial_out_pin_oe_o(pin_oe)
    );

    // ------------------------------------------------------------
    // comparison, verdict and bus tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    function automatic logic [7:0] a(input logic [4:0] idx);
        return {1'b0, idx, 2'b00};
    endfunction : a

    // entered right after a rising edge; released only at the edge that saw ack
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= dat;
        @(negedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 50)
        begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 50)
        begin
            failures++;
            stop_test();
        end
        @(posedge clk_i);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb_cycle

    task automatic wb_read(input logic [7:0] adr, input logic [31:0] exp);
        exp_q.push_back(exp);
        wb_cycle(1'b0, adr, 32'h00000000);
    endtask : wb_read

    // one edge every six clocks, well below the synchroniser's limit and any rate limit
    task automatic pulse(input bit use_vco, input int n);
        repeat (n)
        begin
            if (use_vco)
                vco_in_i <= 1'b1;
            else
                ref_in_i <= 1'b1;
            repeat (3) @(posedge clk_i);
            vco_in_i <= 1'b0;
            ref_in_i <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask : pulse

    // align to a terminal count so that a new ratio is in force afterwards
    task automatic measure(input bit use_vco, input int edges, output int ticks,
                           output int togs);
        int c0;
        int p0;
        int n;
        n = 0;
        c0 = use_vco ? n_cnt : ref_cnt;
        while ((use_vco ? n_cnt : ref_cnt) == c0 && n < 64)
        begin
            pulse(use_vco, 1);
            n++;
        end
        repeat (3) @(posedge clk_i);
        c0 = use_vco ? n_cnt : ref_cnt;
        p0 = pin_cnt;
        pulse(use_vco, edges);
        repeat (3) @(posedge clk_i);
        ticks = (use_vco ? n_cnt : ref_cnt) - c0;
        togs = pin_cnt - p0;
        if (n >= 64)
            failures++;
    endtask : measure

    // ------------------------------------------------------------
    // output watcher: read data against the oldest note, ticks counted
    // ------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (wb_ack_o === 1'b1 && wb_cyc_i === 1'b1 && wb_we_i === 1'b0)
            check(wb_dat_o, (exp_q.size() > 0) ? exp_q.pop_front() : 'x);
        ref_cnt <= ref_cnt + (rtick === 1'b1);
        n_cnt <= n_cnt + (ntick === 1'b1);
        pin_d <= pin;
        pin_cnt <= pin_cnt + (pin !== pin_d);
    end

    // watchdog well beyond the expected run of about 12k cycles
    initial
    begin
        repeat (60000) @(posedge clk_i);
        failures++;
        stop_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        int t;
        int p;
        int v;
        int r;
        void'($urandom(32'ha553b1cd));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb_read(a(IDX_REF_RATIO), {8'h00, RST_REF_RATIO});
        wb_read(a(IDX_N_INT), {8'h00, RST_N_INT});
        wb_read(a(IDX_MOD_CFG), 32'h0);
        wb_read(a(IDX_ANA_EN), 32'h0);
        wb_read(a(IDX_CP_CTL), 32'h0);
        check({hf, dsm, up, dn, pin, pin_oe}, 32'h01);
        $display("reset test done");
        // every modulator mode and offset direction, random magnitude
        for (int m = 0; m < 4; m++)
        begin
            v = $urandom() & 32'h7f;
            wb_cycle(1'b1, a(IDX_MOD_CFG), m << DSM_LSB);
            wb_cycle(1'b1, a(IDX_CP_CTL), (m << CP_DIR_LSB) | (v << CP_MAG_LSB));
            wb_cycle(1'b1, a(IDX_ANA_EN), (m & 1) << HF_BIT);
            check(dsm, m);
            check({up, dn}, {m == CP_DIR_UP, m == CP_DIR_DN});
            check(mag, v);
            check(hf, m & 1);
            wb_read(a(IDX_CP_CTL), (m << CP_DIR_LSB) | (v << CP_MAG_LSB));
        end
        $display("control field test done");
        // widest ratio, then an aliased write above the map must not land
        wb_cycle(1'b1, a(IDX_REF_RATIO), 32'h3fff);
        wb_read(a(IDX_REF_RATIO), 32'h3fff);
        wb_cycle(1'b1, 8'h88, 32'h1);
        wb_read(a(IDX_REF_RATIO), 32'h3fff);
        wb_read(8'h80, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            r = (i < 2) ? i + 1 : $urandom_range(3, 9);
            wb_cycle(1'b1, a(IDX_REF_RATIO), r);
            measure(1'b0, 4 * r, t, p);
            check(t, 4);
        end
        $display("reference divider test done");
        // test pin views: reference, feedback, then a random select from 11 to 31
        wb_cycle(1'b1, a(IDX_REF_RATIO), 32'h2);
        wb_cycle(1'b1, a(IDX_PIN_CFG), PIN_SEL_REF);
        measure(1'b0, 8, t, p);
        check(p, 4);
        wb_cycle(1'b1, a(IDX_PIN_CFG), PIN_SEL_N);
        measure(1'b1, 32, t, p);
        check(t, 2);
        check(p, 2);
        wb_cycle(1'b1, a(IDX_PIN_CFG), $urandom_range(11, 31));
        measure(1'b0, 8, t, p);
        check(p, 0);
        check({pin, pin_oe}, 2'b01);
        $display("test pin test done");
        // feedback divider: widest ratio, random integer ratio, prescaler on
        wb_cycle(1'b1, a(IDX_N_INT), 32'h7ffff);
        wb_read(a(IDX_N_INT), 32'h7ffff);
        r = $urandom_range(16, 24);
        wb_cycle(1'b1, a(IDX_N_INT), r);
        measure(1'b1, 3 * r, t, p);
        check(t, 3);
        wb_cycle(1'b1, a(IDX_ANA_EN), 1 << DIV2_BIT);
        measure(1'b1, 6 * r, t, p);
        check(t, 3);
        wb_cycle(1'b1, a(IDX_ANA_EN), 32'h0);
        // fraction of 0.75: integer mode ignores it, both modulators average it
        wb_cycle(1'b1, a(IDX_N_INT), 32'h10);
        wb_cycle(1'b1, a(IDX_N_FRAC), 32'hc00000);
        wb_read(a(IDX_N_FRAC), 32'hc00000);
        for (int m = 0; m < 3; m++)
        begin
            wb_cycle(1'b1, a(IDX_MOD_CFG), m << DSM_LSB);
            measure(1'b1, 536, t, p);
            check((m == 0) ? (t == 33) : (t >= 31 && t <= 32), 1'b1);
        end
        $display("feedback divider test done");
        // mid-run reset returns the controls to their idle values
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb_read(a(IDX_MOD_CFG), 32'h0);
        wb_read(a(IDX_STATUS), {8'h00, RST_N_INT});
        check({hf, dsm, up, dn}, 32'h0);
        check(exp_q.size(), 0);
        $display("second reset test done");
        stop_test();
    end
endmodule : tb
